/* File: core/timer_regs_regs.vh */
// Register map, field positions and reset values of the standard timer.
// Assumes byte-wide registers, each in the low lane of one 32-bit word.
`ifndef TIMER_REGS_REGS_VH
`define TIMER_REGS_REGS_VH

// ==========================================
// Byte offsets
`define OFS_CONTROL_0        8'h00
`define OFS_TIMER_CONTROL_1  8'h04
`define OFS_COUNTER_LOW      8'h08
`define OFS_COUNTER_HIGH     8'h0C
`define OFS_COMPARE_A_LOW    8'h10
`define OFS_COMPARE_A_HIGH   8'h14
`define OFS_PERIOD_COMPARE   8'h18
`define OFS_FLAGS            8'h1C

// ==========================================
// Control 0 fields
`define C0_PAUSE_BIT   7
`define C0_CLKSEL_HI   6
`define C0_CLKSEL_LO   4
`define C0_ENABLE_BIT  3
`define C0_WRITE_MASK  8'hF8

// ==========================================
// Timer control 1 fields
`define C1_MODE_HI     7
`define C1_MODE_LO     6
`define C1_PINFN_HI    5
`define C1_PINFN_LO    4
`define C1_OC_BIT      3
`define C1_POL_BIT     2
`define C1_DPX_BIT     1
`define C1_CCLR_BIT    0

// ==========================================
// Flag register fields
`define FLAG_A_BIT     0
`define FLAG_P_BIT     1

// ==========================================
// Modes and pin functions
`define MODE_COMPARE   2'h0
`define MODE_PWM       2'h2
`define MODE_TIMER     2'h3
`define PIN_NONE       2'h0
`define PIN_LOW        2'h1
`define PIN_HIGH       2'h2
`define PIN_TOGGLE     2'h3

// ==========================================
// Reset values
`define RST_BYTE       8'h00
`define RST_COUNT      16'h0000

// ==========================================
// Prescaler terminal counts
`define DIV4_LAST      6'h03
`define DIV16_LAST     6'h0F
`define DIV64_LAST     6'h3F

// ==========================================
// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: core/standard_timer.v */
// 16-bit standard timer with comparators A and P, AXI4-Lite registers.
// Assumes all inputs synchronous to clk; sub_clock_tick is a one-cycle
// pulse from a slower clock divider elsewhere in the chip.
//
// Contract
// [R01] Counter readable as two zero-reset bytes
// [R02] Compare A: two RW bytes, full compare
// [R03] Compare P byte matches counter high byte
// [R04] P period P*256, zero means 65536
// [R05] Mode 00 is compare-match output mode
// [R06] Clear-select low: clear on P, both flags
// [R07] Clear-select high: clear on A, A flag
// [R08] Software must not set A to zero
// [R09] A zero: overflow at FFFF, no A flag
// [R10] Pin changes only on A match
// [R11] Pin function picks high, low, toggle
// [R12] Enable rise loads pin initial level
// [R13] Mode 11 like compare, pin unused
// [R14] Software selects PWM with 10/10
// [R15] PWM: swap bit picks period, duty
// [R16] PWM sets flags on each match
// [R17] Swap zero: period P*256, duty A
// [R18] Swap one: period A, duty P*256
// [R19] Duty at or above period: 100%
// [R20] PWM polarity, forced levels, inversion
// [R21] Enable rise clears counter; off holds
// [R22] Pin codes: none, low, high, toggle
// [R23] Counter steps once per selected tick
// [R24] Flags sticky until software clears

`timescale 1ns/100ps

`include "timer_regs_regs.vh"

module standard_timer (
   input wire clk,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sub_clock_tick,
   input wire timer_clock_pin,
   output reg timer_output_pin,
   output reg timer_output_pin_oe,
   output reg a_match_flag,
   output reg p_match_flag
);

// ==========================================
// Register state
reg [7:0] control_0_reg;
reg [7:0] timer_control_1_reg;
reg [7:0] compare_a_low_reg;
reg [7:0] compare_a_high_reg;
reg [7:0] period_compare_reg;
reg [15:0] count_reg;
reg enable_prev_reg;
reg pin_level_reg;
reg [5:0] prescale_reg;
reg ext_pin_prev_reg;

wire [1:0] mode_field = timer_control_1_reg[`C1_MODE_HI:`C1_MODE_LO];
wire [1:0] pin_function_field = timer_control_1_reg[`C1_PINFN_HI:`C1_PINFN_LO];
wire output_control_bit = timer_control_1_reg[`C1_OC_BIT];
wire polarity_invert_bit = timer_control_1_reg[`C1_POL_BIT];
wire duty_period_swap_bit = timer_control_1_reg[`C1_DPX_BIT];
wire clear_select_bit = timer_control_1_reg[`C1_CCLR_BIT];
wire timer_enable_bit = control_0_reg[`C0_ENABLE_BIT];
wire pause_bit = control_0_reg[`C0_PAUSE_BIT];
wire [2:0] clock_select = control_0_reg[`C0_CLKSEL_HI:`C0_CLKSEL_LO];
wire [15:0] compare_a_value = {compare_a_high_reg, compare_a_low_reg};
wire [7:0] compare_p_value = period_compare_reg;

// ==========================================
// AXI4-Lite write channel
reg aw_held_reg;
reg w_held_reg;
reg [7:0] aw_addr_reg;
reg [7:0] w_data_reg;
reg w_lane_reg;

assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
wire wr_hit = do_write && w_lane_reg;

always @(posedge clk) begin
   if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
end

function addr_mapped;
   input [7:0] a;
   begin
      addr_mapped = (a[1:0] == 2'h0) && (a <= `OFS_FLAGS);
   end
endfunction

// ==========================================
// AXI4-Lite read channel
assign s_axi_arready = !s_axi_rvalid;
// Counter bytes are read one at a time, so a carry between two reads is visible

reg [7:0] read_byte;
always @* begin
   case (s_axi_araddr)
      `OFS_CONTROL_0: read_byte = control_0_reg;
      `OFS_TIMER_CONTROL_1: read_byte = timer_control_1_reg;
      // [R01] Live counter bytes
      `OFS_COUNTER_LOW: read_byte = count_reg[7:0];
      `OFS_COUNTER_HIGH: read_byte = count_reg[15:8];
      `OFS_COMPARE_A_LOW: read_byte = compare_a_low_reg;
      `OFS_COMPARE_A_HIGH: read_byte = compare_a_high_reg;
      `OFS_PERIOD_COMPARE: read_byte = period_compare_reg;
      `OFS_FLAGS: read_byte = {6'h00, p_match_flag, a_match_flag};
      default: read_byte = 8'h00;
   endcase
end

always @(posedge clk) begin
   if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, read_byte};
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
   end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
   end
end

// ==========================================
// Register writes
wire flag_write = wr_hit && (aw_addr_reg == `OFS_FLAGS);
wire clr_a = flag_write && w_data_reg[`FLAG_A_BIT];
wire clr_p = flag_write && w_data_reg[`FLAG_P_BIT];

always @(posedge clk) begin
   if (rst) begin
      control_0_reg <= `RST_BYTE;
      timer_control_1_reg <= `RST_BYTE;
      // [R02] Compare A bytes reset to zero
      compare_a_low_reg <= `RST_BYTE;
      compare_a_high_reg <= `RST_BYTE;
      // [R03] Compare P byte reset to zero
      period_compare_reg <= `RST_BYTE;
   end else if (wr_hit) begin
      case (aw_addr_reg)
         `OFS_CONTROL_0: control_0_reg <= w_data_reg & `C0_WRITE_MASK;
         `OFS_TIMER_CONTROL_1: timer_control_1_reg <= w_data_reg;
         `OFS_COMPARE_A_LOW: compare_a_low_reg <= w_data_reg;
         `OFS_COMPARE_A_HIGH: compare_a_high_reg <= w_data_reg;
         `OFS_PERIOD_COMPARE: period_compare_reg <= w_data_reg;
         default: ;
      endcase
   end
end

// ==========================================
// Counter clock selection
// External pin edges are sampled, so a pin faster than clk/2 is lost; sub ticks count directly.
always @(posedge clk) begin
   if (rst) begin
      prescale_reg <= 6'h00;
      ext_pin_prev_reg <= 1'b0;
   end else begin
      prescale_reg <= prescale_reg + 6'h01;
      ext_pin_prev_reg <= timer_clock_pin;
   end
end

reg count_tick;
always @* begin
   case (clock_select)
      3'h0: count_tick = ({4'h0, prescale_reg[1:0]} == `DIV4_LAST);
      3'h1: count_tick = 1'b1;
      3'h2: count_tick = ({2'h0, prescale_reg[3:0]} == `DIV16_LAST);
      3'h3: count_tick = (prescale_reg == `DIV64_LAST);
      3'h4: count_tick = sub_clock_tick;
      3'h5: count_tick = sub_clock_tick;
      3'h6: count_tick = timer_clock_pin && !ext_pin_prev_reg;
      default: count_tick = !timer_clock_pin && ext_pin_prev_reg;
   endcase
end

// ==========================================
// Comparators
wire enable_rise = timer_enable_bit && !enable_prev_reg;
// [R23] One step per selected tick
wire step = timer_enable_bit && !enable_rise && !pause_bit && count_tick;
wire [15:0] count_inc = count_reg + 16'h0001;
// [R02] Full 16-bit compare; [R09] A of zero never matches
reg a_hit;
always @* begin
   a_hit = 1'b0;
   if (step && (compare_a_value != 16'h0000)) begin
      a_hit = (count_inc == compare_a_value);
   end
end
// [R03] [R04] P matches the high byte; zero means overflow
reg p_hit;
always @* begin
   if (compare_p_value == 8'h00) begin
      // A zero byte can never be reached, so the last count stands in
      p_hit = step && (count_reg == 16'hFFFF);
   end else begin
      p_hit = step && (count_inc == {compare_p_value, 8'h00});
   end
end
wire is_pwm = (mode_field == `MODE_PWM);

reg clear_on;
reg set_a;
reg set_p;
always @* begin
   if (is_pwm) begin
      // [R15] Swap bit picks the clearing comparator
      clear_on = duty_period_swap_bit ? a_hit : p_hit;
      // [R16] Both flags in PWM
      set_a = a_hit;
      set_p = p_hit;
   end else if (clear_select_bit) begin
      // [R07] Clear on A, P flag never set
      clear_on = a_hit;
      set_a = a_hit;
      set_p = 1'b0;
   end else begin
      // [R06] Clear on P or overflow
      clear_on = p_hit;
      set_a = a_hit;
      set_p = p_hit;
   end
end

// ==========================================
// Counter
always @(posedge clk) begin
   if (rst) begin
      count_reg <= `RST_COUNT;
      enable_prev_reg <= 1'b0;
   end else begin
      enable_prev_reg <= timer_enable_bit;
      // [R21] Enable rise restarts from zero
      if (enable_rise) begin
         count_reg <= `RST_COUNT;
      end else if (step) begin
         // [R05] Clear by match or overflow
         count_reg <= clear_on ? `RST_COUNT : count_inc;
      end
   end
end

// ==========================================
// Match flags
// Set beats a clear written in the same cycle.
always @(posedge clk) begin
   if (rst) begin
      a_match_flag <= 1'b0;
      p_match_flag <= 1'b0;
   end else begin
      // [R24] Sticky until written with one
      a_match_flag <= (a_match_flag && !clr_a) || set_a;
      p_match_flag <= (p_match_flag && !clr_p) || set_p;
   end
end

// ==========================================
// Compare-match pin level
always @(posedge clk) begin
   if (rst) begin
      pin_level_reg <= 1'b0;
   end else if (enable_rise) begin
      // [R12] Initial level on enable rise
      pin_level_reg <= output_control_bit;
   end else if (set_a && !is_pwm) begin
      // [R10] [R11] [R22] Only an A match moves the pin
      case (pin_function_field)
         `PIN_LOW: pin_level_reg <= 1'b0;
         `PIN_HIGH: pin_level_reg <= 1'b1;
         `PIN_TOGGLE: pin_level_reg <= !pin_level_reg;
         default: pin_level_reg <= pin_level_reg;
      endcase
   end
end

// ==========================================
// PWM waveform
// [R17] [R18] Duty source follows the swap bit
// [R19] Duty at or past period stays active
wire duty_a_active = (count_reg < compare_a_value);
wire duty_p_active = (compare_p_value == 8'h00) || (count_reg[15:8] < compare_p_value);
reg pwm_active;
always @* begin
   if (duty_period_swap_bit) begin
      pwm_active = duty_p_active;
   end else begin
      pwm_active = duty_a_active;
   end
end

reg pwm_level;
always @* begin
   // [R20] Active level from output control, fixed forcing
   case (pin_function_field)
      `PIN_NONE: pwm_level = !output_control_bit;
      `PIN_LOW: pwm_level = output_control_bit;
      default: pwm_level = pwm_active ? output_control_bit : !output_control_bit;
   endcase
end

// ==========================================
// Output pin
reg pin_drive_next;
always @* begin
   // Compare modes show the latched level, PWM the live waveform
   if (is_pwm) begin
      pin_drive_next = pwm_level;
   end else begin
      pin_drive_next = pin_level_reg;
   end
end

always @(posedge clk) begin
   if (rst) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_oe <= 1'b0;
   end else begin
      // [R13] Timer/counter mode releases the pin
      timer_output_pin_oe <= (mode_field != `MODE_TIMER);
      // [R20] Polarity bit inverts the final level
      timer_output_pin <= pin_drive_next ^ polarity_invert_bit;
   end
end

endmodule

/* File: tb/pin_load.sv */
// Load on the timer output pin, seen as the level of the pad.
// Assumes a pull-down holds the pad low while the timer releases it.
`timescale 1ns/100ps
module pin_load (
   input wire pin,
   input wire oe,
   output wire pad
);
   // ==========
   // Pad level
   // Released pad reads the pull-down, never the last driven value
   assign pad = oe ? pin : 1'b0;
endmodule

/* File: tb/standard_timer_properties.sv */
// Checker for the register bus handshakes and the sticky match flags.
// Assumes it is bound to the timer top and sees only its ports.
`timescale 1ns/100ps
module standard_timer_properties (
   input wire clk,
   input wire rst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire a_match_flag,
   input wire p_match_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========
   // Bus
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_bresp_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
   property p_rdata_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
   property p_write_answer;
      s_wr_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_read_answer;
      s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("bad read answer");
   property p_write_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_write_refuse: assert property (p_write_refuse) else $error("write taken during response");
   property p_read_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_read_refuse: assert property (p_read_refuse) else $error("read taken during answer");
   // ==========
   // Flags
   // Only a software write may clear a flag
   property p_a_sticky;
      $fell(a_match_flag) |-> ##[0:1] s_axi_bvalid;
   endproperty
   a_a_sticky: assert property (p_a_sticky) else $error("A flag fell alone");
   property p_p_sticky;
      $fell(p_match_flag) |-> ##[0:1] s_axi_bvalid;
   endproperty
   a_p_sticky: assert property (p_p_sticky) else $error("P flag fell alone");
endmodule

/* File: tb/standard_timer_tb.sv */
// Self-checking bench: registers, compare-match pin, P clear, PWM duty.
// Assumes the timer, the pin load and the checker are compiled first.
`timescale 1ns/100ps
`include "timer_regs_regs.vh"
module standard_timer_tb;
   logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, sub_clock_tick = 0, timer_clock_pin = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000, rd, hi;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [1:0] rs;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire timer_output_pin, timer_output_pin_oe, a_match_flag, p_match_flag, pad;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int num_errors = 0, samples_checked = 0, seed = 50;
   standard_timer u_standard_timer (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_clock_tick,
      .timer_clock_pin, .timer_output_pin, .timer_output_pin_oe, .a_match_flag, .p_match_flag);
   pin_load u_pin_load (.pin(timer_output_pin), .oe(timer_output_pin_oe), .pad(pad));
   always #50 clk = ~clk;
   // Unselected clock sources still toggle, so a wrong select shows up
   always @(posedge clk) begin
      sub_clock_tick <= ($random(seed) & 7) == 0;
      timer_clock_pin <= $random(seed);
   end
   // ==========
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Each request holds until the rising edge that samples its ready high
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic b;
      int n;
      b = 1'b0;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         b = s_axi_bvalid;
         n++;
      end while (!b && n < 40);
      s_axi_bready <= 1'b0;
      check(b, 1);
   endtask
   task automatic rdr(input logic [7:0] a);
      logic r;
      int n;
      r = 1'b0;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         r = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         n++;
      end while (!r && n < 40);
      s_axi_rready <= 1'b0;
      check(r, 1);
   endtask
   function automatic int pwm_high(input logic s, input logic pol, input int a, input int p);
      int per, duty;
      per = s ? a : (p == 0 ? 65536 : p * 256);
      duty = s ? (p == 0 ? 65536 : p * 256) : a;
      duty = duty < per ? duty : per;
      return pol ? per - duty : duty;
   endfunction
   // ==========
   // Sequence
   initial begin
      logic [15:0] av;
      logic oc;
      int n;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rdr(8'(i * 4));
         check(rd, 0);
         check(rs, i == 8 ? `RESP_SLVERR : `RESP_OKAY);
      end
      wr(`OFS_COUNTER_LOW, 8'h5A);
      rdr(`OFS_COUNTER_LOW);
      check(rd, 0);
      for (int k = 0; k < 4; k++) begin
         oc = k == 1 ? 1'b1 : k == 2 ? 1'b0 : 1'($random(seed));
         av = 16'h0100 | 16'($random(seed) & 255);
         wr(`OFS_COMPARE_A_LOW, av[7:0]);
         wr(`OFS_COMPARE_A_HIGH, av[15:8]);
         rdr(`OFS_COMPARE_A_HIGH);
         check(rd, av[15:8]);
         wr(`OFS_FLAGS, 8'h03);
         check(a_match_flag, 0);
         wr(`OFS_TIMER_CONTROL_1, {`MODE_COMPARE, 2'(k), oc, 3'b001});
         wr(`OFS_CONTROL_0, ($random(seed) & 1) ? 8'h18 : 8'h08);
         // The initial level reaches the pin two edges after the write ends
         repeat (2) @(negedge clk);
         check(timer_output_pin, oc);
         for (n = 0; n < 3000 && !a_match_flag; n++) @(negedge clk);
         wr(`OFS_CONTROL_0, 8'h10);
         check({a_match_flag, p_match_flag}, 2'b10);
         check(pad, k == 0 ? oc : k == 1 ? 1'b0 : k == 2 ? 1'b1 : !oc);
         rdr(`OFS_COUNTER_LOW);
         hi = rd;
         rdr(`OFS_COUNTER_LOW);
         check(rd, hi);
      end
      wr(`OFS_PERIOD_COMPARE, 8'h01);
      wr(`OFS_COMPARE_A_HIGH, 8'h00);
      wr(`OFS_COMPARE_A_LOW, 8'h40);
      wr(`OFS_FLAGS, 8'h03);
      wr(`OFS_TIMER_CONTROL_1, 8'h00);
      wr(`OFS_CONTROL_0, 8'h18);
      for (n = 0; n < 600 && !p_match_flag; n++) @(negedge clk);
      check({a_match_flag, p_match_flag}, 2'b11);
      rdr(`OFS_COUNTER_HIGH);
      check(rd, 0);
      wr(`OFS_CONTROL_0, 8'h10);
      // Polarity set, so a pad still driven would read high
      wr(`OFS_TIMER_CONTROL_1, {`MODE_TIMER, 6'h04});
      @(negedge clk);
      check(pad, 0);
      // PWM duty counted over one period
      for (int k = 0; k < 4; k++) begin
         av = k == 2 ? 16'h0180 : k == 3 ? 16'h00C8 : 16'h0010 + 16'($random(seed) & 127);
         wr(`OFS_CONTROL_0, 8'h10);
         wr(`OFS_COMPARE_A_LOW, av[7:0]);
         wr(`OFS_COMPARE_A_HIGH, av[15:8]);
         wr(`OFS_PERIOD_COMPARE, k == 3 ? 8'h00 : 8'h01);
         wr(`OFS_FLAGS, 8'h03);
         wr(`OFS_TIMER_CONTROL_1, {`MODE_PWM, `PIN_HIGH, 1'b1, k == 1, k == 3, 1'b0});
         wr(`OFS_CONTROL_0, 8'h18);
         repeat (256) @(negedge clk);
         hi = 0;
         for (int j = 0; j < (k == 3 ? 200 : 256); j++) begin
            @(negedge clk);
            hi += pad;
         end
         check(hi, pwm_high(k == 3, k == 1, av, k == 3 ? 0 : 1));
         check({a_match_flag, p_match_flag}, k == 3 ? 2'b10 : k == 2 ? 2'b01 : 2'b11);
      end
      for (int j = 0; j < 2; j++) begin
         wr(`OFS_TIMER_CONTROL_1, {`MODE_PWM, 2'(j), 4'h8});
         @(negedge clk);
         check(pad, j);
      end
      // Enable rise clears, pause holds, run counts
      wr(`OFS_CONTROL_0, 8'h10);
      wr(`OFS_CONTROL_0, 8'h98);
      repeat (20) @(negedge clk);
      rdr(`OFS_COUNTER_LOW);
      check(rd, 0);
      wr(`OFS_CONTROL_0, 8'h18);
      rdr(`OFS_COUNTER_LOW);
      check(rd != 0, 1);
      conclude();
   end
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule
bind standard_timer standard_timer_properties u_standard_timer_properties (.clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .a_match_flag, .p_match_flag);
